//--- bench/helical_print_control_tb.sv
// Purpose: self-checking bench of the print controller
// Assumes: shortened hold counts
// Notes: struck codes come from the mechanism model
`timescale 1ns/1ps
module helical_print_control_tb;
  localparam [59:0] EXP_SHORT = {35'h0, 5'h01, 5'h02, 5'h00, 5'h0D, 5'h0C};
  localparam [59:0] EXP_FMT = {10'h0, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0A, 5'h06,
    5'h07, 5'h0D, 5'h0C};
  localparam [59:0] EXP_ZERO = {45'h0, 5'h00, 5'h0C, 5'h0B};
  localparam [59:0] EXP_LEAD = {30'h0, 5'h00, 5'h0A, 5'h00, 5'h05, 5'h0C, 5'h0B};
  reg clk = 1'b0, srst = 1'b1, line_valid = 1'b0, line_dp_en = 1'b0, line_sep_en = 1'b0;
  reg [59:0] line_digits = 60'h0;
  reg [3:0] line_dp_cnt = 4'h0;
  reg [4:0] line_sym0 = 5'h00, line_sym1 = 5'h00;
  wire line_ready, busy, motor_on, carriage_start, hammer_drive, line_feed;
  wire carriage_home, screw_home, digit_home, char_pulse;
  integer num_errors = 0, checked = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  helical_print_control #(.MOTOR_HOLD_CYC(200), .CS_HOLD_CYC(4), .LF_HOLD_CYC(4),
    .HAMMER_CYC(2)) uut (.clk(clk), .srst(srst), .line_valid(line_valid),
    .line_ready(line_ready), .line_digits(line_digits), .line_dp_en(line_dp_en),
    .line_dp_cnt(line_dp_cnt), .line_sym0(line_sym0), .line_sym1(line_sym1),
    .line_sep_en(line_sep_en), .carriage_home(carriage_home), .screw_home(screw_home),
    .digit_home(digit_home), .char_pulse(char_pulse), .motor_on(motor_on),
    .carriage_start(carriage_start), .hammer_drive(hammer_drive), .line_feed(line_feed),
    .busy(busy));
  print_mech_model mdl (.clk(clk), .motor_on(motor_on), .carriage_start(carriage_start),
    .hammer_drive(hammer_drive), .line_feed(line_feed), .carriage_home(carriage_home),
    .screw_home(screw_home), .digit_home(digit_home), .char_pulse(char_pulse));
  // compare and report
  task check(input [31:0] act, input [31:0] exp);
    begin
      checked = checked + 1;
      if (act !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got %h exp %h", $time, act, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // bounded wait for idle
  task wait_ready;
    integer i;
    begin
      i = 0;
      while (line_ready !== 1'b1 && i < 9000) begin
        @(posedge clk);
        #2;
        i = i + 1;
      end
      if (i >= 9000) begin
        num_errors = num_errors + 1;
        summarize;
      end
    end
  endtask
  // print one line and judge strikes and feeds
  task run_line(input [59:0] d, input dp, input [3:0] dc, input sep, input [59:0] e,
    input integer n);
    integer k, s0, f0;
    begin
      wait_ready;
      s0 = mdl.nstrike;
      f0 = mdl.nfeed;
      line_digits = d;
      line_dp_en = dp;
      line_dp_cnt = dc;
      line_sep_en = sep;
      line_sym0 = e[4:0];
      line_sym1 = e[9:5];
      line_valid = 1'b1;
      @(posedge clk);
      #2;
      line_valid = 1'b0;
      check(busy, 1'b1);
      check(motor_on, 1'b1);
      wait_ready;
      check(mdl.nstrike - s0, n);
      for (k = 0; k < n; k = k + 1) check(mdl.strike[s0 + k], e[5 * k +: 5]);
      check(mdl.nfeed - f0, 1);
    end
  endtask
  task test_short;
    begin
      run_line(60'h120, 1'b0, 4'h0, 1'b0, EXP_SHORT, 5);
      $display("test_short done");
    end
  endtask
  task test_format;
    begin
      check(motor_on, 1'b1);
      run_line(60'h1234567, 1'b1, 4'h2, 1'b1, EXP_FMT, 10);
      $display("test_format done");
    end
  endtask
  task test_zero;
    begin
      run_line(60'h0, 1'b0, 4'h0, 1'b0, EXP_ZERO, 3);
      run_line(60'h5, 1'b1, 4'h2, 1'b0, EXP_LEAD, 6);
      $display("test_zero done");
    end
  endtask
  task test_hold;
    begin
      repeat (150) @(posedge clk);
      #2;
      check(motor_on, 1'b1);
      repeat (60) @(posedge clk);
      #2;
      check(motor_on, 1'b0);
      $display("test_hold done");
    end
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #2;
    srst = 1'b0;
    check(line_ready, 1'b1);
    check(motor_on, 1'b0);
    test_short;
    test_format;
    test_zero;
    test_hold;
    summarize;
  end
endmodule
bind helical_print_control print_ctl_props #(.MOTOR_HOLD_CYC(MOTOR_HOLD_CYC),
  .CS_HOLD_CYC(CS_HOLD_CYC), .LF_HOLD_CYC(LF_HOLD_CYC), .HAMMER_CYC(HAMMER_CYC)) chk (
  .clk(clk), .srst(srst), .line_valid(line_valid), .line_ready(line_ready),
  .line_digits(line_digits), .line_dp_en(line_dp_en), .line_dp_cnt(line_dp_cnt),
  .line_sym0(line_sym0), .line_sym1(line_sym1), .line_sep_en(line_sep_en),
  .carriage_home(carriage_home), .screw_home(screw_home), .digit_home(digit_home),
  .char_pulse(char_pulse), .motor_on(motor_on), .carriage_start(carriage_start),
  .hammer_drive(hammer_drive), .line_feed(line_feed), .busy(busy));

//--- bench/print_ctl_props.sv
// Purpose: port checks of the print controller
// Assumes: hold counts handed in from the design
// Notes: sees top ports only
`timescale 1ns/1ps
module print_ctl_props #(
  parameter [31:0] MOTOR_HOLD_CYC = 32'd200,
  parameter [31:0] CS_HOLD_CYC = 32'd4,
  parameter [31:0] LF_HOLD_CYC = 32'd4,
  parameter [31:0] HAMMER_CYC = 32'd2
) (
  input wire clk, input wire srst, input wire line_valid, input wire line_ready,
  input wire [59:0] line_digits, input wire line_dp_en, input wire [3:0] line_dp_cnt,
  input wire [4:0] line_sym0, input wire [4:0] line_sym1, input wire line_sep_en,
  input wire carriage_home, input wire screw_home, input wire digit_home,
  input wire char_pulse, input wire motor_on, input wire carriage_start,
  input wire hammer_drive, input wire line_feed, input wire busy
);
  reg [31:0] cs_n_ff = 0, lf_n_ff = 0, hm_n_ff = 0, idle_n_ff = 0;
  // high-time and idle-time counters
  always @(posedge clk) begin
    cs_n_ff <= carriage_start ? cs_n_ff + 32'h1 : 32'h0;
    lf_n_ff <= line_feed ? lf_n_ff + 32'h1 : 32'h0;
    hm_n_ff <= hammer_drive ? hm_n_ff + 32'h1 : 32'h0;
    idle_n_ff <= (srst || busy) ? 32'h0 : idle_n_ff + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take; line_valid && line_ready; endsequence
  sequence s_feed_end; $fell(line_feed); endsequence
  take_answer_a: assert property (s_take |=> busy && motor_on && !line_ready)
    else $error("request not answered");
  busy_motor_a: assert property (busy |-> motor_on)
    else $error("motor off while busy");
  start_home_a: assert property ($rose(carriage_start) |-> carriage_home && busy)
    else $error("carriage start away from home");
  start_len_a: assert property ($fell(carriage_start) |-> cs_n_ff == CS_HOLD_CYC)
    else $error("carriage start width wrong");
  feed_len_a: assert property (s_feed_end |-> lf_n_ff == LF_HOLD_CYC)
    else $error("line feed width wrong");
  feed_idle_a: assert property (s_feed_end |-> ##[0:2] line_ready)
    else $error("no idle after line feed");
  hammer_len_a: assert property ($fell(hammer_drive) |-> hm_n_ff == HAMMER_CYC)
    else $error("hammer width wrong");
  hammer_busy_a: assert property (hammer_drive |-> busy && !line_feed)
    else $error("hammer outside printing");
  motor_hold_a: assert property ($fell(motor_on) |-> !busy &&
    idle_n_ff + 32'd2 >= MOTOR_HOLD_CYC && idle_n_ff <= MOTOR_HOLD_CYC + 32'd2)
    else $error("motor hold time wrong");
endmodule

//--- bench/print_mech_model.sv
// Purpose: behavioural helical printer mechanism
// Assumes: wheel and screw turn only while the motor runs
// Notes: logs struck wheel codes and feeds
`timescale 1ns/1ps
module print_mech_model (
  input wire clk, input wire motor_on, input wire carriage_start,
  input wire hammer_drive, input wire line_feed,
  output reg carriage_home = 1'b1, output reg screw_home = 1'b0,
  output reg digit_home = 1'b0, output reg char_pulse = 1'b0
);
  reg [7:0] tick_ff = 8'h00;
  reg [6:0] scr_ff = 7'h00;
  reg [4:0] pos_ff = 5'h00;
  reg [2:0] prev_ff = 3'h0;
  reg [4:0] strike [0:31];
  integer nstrike = 0, nfeed = 0;
  // wheel, screw and carriage motion
  always @(posedge clk) begin
    prev_ff <= {hammer_drive, line_feed, carriage_start};
    if (motor_on) begin
      tick_ff <= (tick_ff == 8'hF7) ? 8'h00 : tick_ff + 8'h01;
      scr_ff <= scr_ff + 7'h01;
    end
    digit_home <= motor_on && tick_ff < 8'h03;
    char_pulse <= motor_on && tick_ff >= 8'h08 && tick_ff[2:0] < 3'h3;
    screw_home <= motor_on && scr_ff < 7'h03;
    if (tick_ff == 8'h00) begin
      pos_ff <= 5'h00;
    end else if (motor_on && tick_ff >= 8'h08 && tick_ff[2:0] == 3'h0) begin
      pos_ff <= pos_ff + 5'h01;
    end
    if (carriage_start && !prev_ff[0]) begin
      carriage_home <= 1'b0;
    end
    if (line_feed && !prev_ff[1]) begin
      carriage_home <= 1'b1;
      nfeed <= nfeed + 1;
    end
    if (hammer_drive && !prev_ff[2]) begin
      strike[nstrike] <= pos_ff;
      nstrike <= nstrike + 1;
    end
  end
endmodule

//--- verilog/helical_print_control.v
// Purpose: motor, carriage, hammer and feed control of a helical printer
// Assumes: printer strobes are asynchronous pins, line data is on clk
// Notes: one wheel revolution per column, blank code leaves a space
// Function
// - motor runs while a line is pending
// - motor stops shortly after, unless re-requested
// - right to left, symbols, then digits LSD first
// - 15 digits, point, two symbols, four spaces
// - line ends at most significant nonzero digit; runs on to digit dp_cnt_ff when the point is on and dp_cnt_ff is higher
// - one paper advance per line cycle
// - hammer fires when wanted character arrives
// - timing wheel strobes locate characters
// - start line only at carriage home
// - carriage start needs carriage and screw home
// - motor off after 1.5 s idle
// - 30 pulses plus home identify character
// - line feed ends printing of a line
`timescale 1ns/1ps
`include "print_ctl_map.vh"
module helical_print_control #(
  parameter [31:0] MOTOR_HOLD_CYC = `MOTOR_HOLD_CYC,
  parameter [31:0] CS_HOLD_CYC = `CS_HOLD_CYC,
  parameter [31:0] LF_HOLD_CYC = `LF_HOLD_CYC,
  parameter [31:0] HAMMER_CYC = `HAMMER_CYC
) (
  input wire clk,
  input wire srst,
  input wire line_valid,
  output wire line_ready,
  input wire [59:0] line_digits,
  input wire line_dp_en,
  input wire [3:0] line_dp_cnt,
  input wire [4:0] line_sym0,
  input wire [4:0] line_sym1,
  input wire line_sep_en,
  input wire carriage_home,
  input wire screw_home,
  input wire digit_home,
  input wire char_pulse,
  output wire motor_on,
  output wire carriage_start,
  output wire hammer_drive,
  output wire line_feed,
  output wire busy
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire car_home_lvl;
  wire screw_rise;
  wire dhome_rise;
  wire char_rise;

  // four printer status inputs, all resynchronised
  sync_edge u_car (.clk(clk), .srst(srst), .pin(carriage_home),
    .level(car_home_lvl), .rise());
  sync_edge u_screw (.clk(clk), .srst(srst), .pin(screw_home),
    .level(), .rise(screw_rise));
  sync_edge u_dhome (.clk(clk), .srst(srst), .pin(digit_home),
    .level(), .rise(dhome_rise));
  sync_edge u_char (.clk(clk), .srst(srst), .pin(char_pulse),
    .level(), .rise(char_rise));

  // ----------------------------------------------------------------
  // state and data registers
  // ----------------------------------------------------------------
  reg [2:0] state_ff, nxt_state;
  reg [59:0] digits_ff;
  reg dp_en_ff, sep_en_ff;
  reg [3:0] dp_cnt_ff;
  reg [4:0] sym0_ff, sym1_ff;
  reg [2:0] phase_ff, nxt_phase;
  reg [3:0] idx_ff, nxt_idx;
  reg [1:0] grp_ff, nxt_grp;
  reg [2:0] sep_ff, nxt_sep;
  reg [4:0] pos_ff;
  reg armed_ff, check_ff, fired_ff;
  reg motor_ff, cs_ff, ham_ff, lf_ff;
  reg [31:0] sol_cnt_ff, ham_cnt_ff, motor_cnt_ff;
  reg [3:0] msd;
  reg [3:0] last_idx;
  reg [4:0] cur_code;
  reg col_last;
  integer k;

  assign line_ready = (state_ff == `ST_IDLE);
  assign motor_on = motor_ff;
  assign carriage_start = cs_ff;
  assign hammer_drive = ham_ff;
  assign line_feed = lf_ff;
  assign busy = (state_ff != `ST_IDLE);

  // ----------------------------------------------------------------
  // line layout decode
  // ----------------------------------------------------------------
  // highest nonzero digit; zeros above it are printed only up to digit dp_cnt_ff when the point is on
  always @* begin
    msd = 4'h0;
    for (k = 0; k < `MAX_DIGITS; k = k + 1) begin
      if (digits_ff[k*4 +: 4] != 4'h0) begin
        msd = k[3:0];
      end
    end
    last_idx = msd;
    if (dp_en_ff && (dp_cnt_ff > msd)) begin
      last_idx = dp_cnt_ff; // keep a leading zero before the point
    end
  end

  // wheel code of the column now in print position
  always @* begin
    case (phase_ff)
      `PH_SYM0: cur_code = sym0_ff;
      `PH_SYM1: cur_code = sym1_ff;
      `PH_DIG: cur_code = {1'b0, digits_ff[{idx_ff, 2'b00} +: 4]};
      `PH_DP: cur_code = `CODE_DP;
      default: cur_code = `CODE_BLANK;
    endcase
  end

  // next column: symbols, then digits LSD up, point and spaces between
  always @* begin
    nxt_phase = phase_ff;
    nxt_idx = idx_ff;
    nxt_grp = grp_ff;
    nxt_sep = sep_ff;
    col_last = 1'b0;
    case (phase_ff)
      `PH_SYM0: nxt_phase = `PH_SYM1;
      `PH_SYM1: begin
        nxt_phase = `PH_DIG;
        nxt_idx = 4'h0;
      end
      `PH_DIG: begin
        if (idx_ff == last_idx) begin
          col_last = 1'b1;
        end else if (dp_en_ff && (idx_ff + 4'h1 == dp_cnt_ff)) begin
          nxt_phase = `PH_DP;
        end else if (!dp_en_ff || (idx_ff >= dp_cnt_ff)) begin
          nxt_grp = (grp_ff == `GRP_LAST) ? 2'h0 : grp_ff + 2'h1;
          if (sep_en_ff && (grp_ff == `GRP_LAST) && (sep_ff < `MAX_SEPS)) begin
            nxt_phase = `PH_SEP;
            nxt_sep = sep_ff + 3'h1;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end else begin
          nxt_idx = idx_ff + 4'h1;
        end
      end
      default: begin
        nxt_phase = `PH_DIG;
        nxt_idx = idx_ff + 4'h1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // controller sequence
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_IDLE: if (line_valid) nxt_state = `ST_ENGAGE;
      `ST_ENGAGE: if (car_home_lvl && screw_rise) nxt_state = `ST_START;
      `ST_START: if (sol_cnt_ff == 32'h0) nxt_state = `ST_COLUMN;
      `ST_COLUMN: if (armed_ff && dhome_rise && col_last && !ham_ff) nxt_state = `ST_FEED;
      `ST_FEED: if (sol_cnt_ff == 32'h0) nxt_state = `ST_IDLE;
      default: nxt_state = `ST_IDLE;
    endcase
  end

  // state, line latch and column tracking
  always @(posedge clk) begin
    if (srst) begin
      state_ff <= `ST_IDLE;
      digits_ff <= 60'h0;
      dp_en_ff <= 1'b0;
      sep_en_ff <= 1'b0;
      dp_cnt_ff <= 4'h0;
      sym0_ff <= `CODE_BLANK;
      sym1_ff <= `CODE_BLANK;
      phase_ff <= `PH_SYM0;
      idx_ff <= 4'h0;
      grp_ff <= 2'h0;
      sep_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == `ST_IDLE && line_valid) begin
        digits_ff <= line_digits;
        dp_en_ff <= line_dp_en;
        sep_en_ff <= line_sep_en;
        dp_cnt_ff <= line_dp_cnt;
        sym0_ff <= line_sym0;
        sym1_ff <= line_sym1;
        phase_ff <= `PH_SYM0;
        idx_ff <= 4'h0;
        grp_ff <= 2'h0;
        sep_ff <= 3'h0;
      end else if (state_ff == `ST_COLUMN && armed_ff && dhome_rise && !col_last) begin
        phase_ff <= nxt_phase;
        idx_ff <= nxt_idx;
        grp_ff <= nxt_grp;
        sep_ff <= nxt_sep;
      end
    end
  end

  // ----------------------------------------------------------------
  // wheel position and hammer timing
  // ----------------------------------------------------------------
  // home clears the count, each character pulse advances it, holding at 29
  always @(posedge clk) begin
    if (srst) begin
      pos_ff <= 5'h0;
      armed_ff <= 1'b0;
      check_ff <= 1'b0;
      fired_ff <= 1'b0;
      ham_ff <= 1'b0;
      ham_cnt_ff <= 32'h0;
    end else begin
      check_ff <= 1'b0;
      if (dhome_rise) begin
        pos_ff <= 5'h0;
        check_ff <= 1'b1;
        fired_ff <= 1'b0;
        armed_ff <= (state_ff == `ST_COLUMN) && (nxt_state == `ST_COLUMN);
      end else if (char_rise && pos_ff < `WHEEL_CHARS - 5'h1) begin
        pos_ff <= pos_ff + 5'h1;
        check_ff <= 1'b1;
      end
      if (state_ff != `ST_COLUMN) begin
        armed_ff <= 1'b0;
      end
      if (ham_ff) begin
        if (ham_cnt_ff == 32'h0) begin
          ham_ff <= 1'b0;
        end else begin
          ham_cnt_ff <= ham_cnt_ff - 32'h1;
        end
      end else if (armed_ff && check_ff && !fired_ff && pos_ff == cur_code) begin
        ham_ff <= 1'b1;
        fired_ff <= 1'b1;
        ham_cnt_ff <= HAMMER_CYC - 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // solenoids and motor
  // ----------------------------------------------------------------
  // carriage start and line feed share one hold timer
  always @(posedge clk) begin
    if (srst) begin
      cs_ff <= 1'b0;
      lf_ff <= 1'b0;
      sol_cnt_ff <= 32'h0;
    end else begin
      if (state_ff == `ST_ENGAGE && nxt_state == `ST_START) begin
        cs_ff <= 1'b1;
        sol_cnt_ff <= CS_HOLD_CYC - 32'h1;
      end else if (state_ff == `ST_COLUMN && nxt_state == `ST_FEED) begin
        lf_ff <= 1'b1;
        sol_cnt_ff <= LF_HOLD_CYC - 32'h1;
      end else if (sol_cnt_ff != 32'h0) begin
        sol_cnt_ff <= sol_cnt_ff - 32'h1;
      end else begin
        cs_ff <= 1'b0;
        lf_ff <= 1'b0;
      end
    end
  end

  // motor on while busy, held after the line until idle time runs out
  always @(posedge clk) begin
    if (srst) begin
      motor_ff <= 1'b0;
      motor_cnt_ff <= 32'h0;
    end else if (nxt_state != `ST_IDLE) begin
      motor_ff <= 1'b1;
      motor_cnt_ff <= MOTOR_HOLD_CYC - 32'h1;
    end else if (motor_cnt_ff != 32'h0) begin
      motor_cnt_ff <= motor_cnt_ff - 32'h1;
    end else begin
      motor_ff <= 1'b0;
    end
  end
endmodule

//--- verilog/print_ctl_map.vh
// Purpose: named constants for the helical printer line controller
// Assumes: 40 MHz system clock
// Notes: timing figures kept in their own units, cycle counts derived
`ifndef PRINT_CTL_MAP_VH
`define PRINT_CTL_MAP_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_KHZ 40000
`define MOTOR_HOLD_MS 1500
`define CS_HOLD_MS 10
`define LF_HOLD_MS 20
`define HAMMER_US 300
`define MOTOR_HOLD_CYC (`MOTOR_HOLD_MS * `CLK_KHZ)
`define CS_HOLD_CYC (`CS_HOLD_MS * `CLK_KHZ)
`define LF_HOLD_CYC (`LF_HOLD_MS * `CLK_KHZ)
`define HAMMER_CYC ((`HAMMER_US * `CLK_KHZ) / 1000)

// ----------------------------------------------------------------
// line format
// ----------------------------------------------------------------
`define MAX_DIGITS 15
`define MAX_SEPS 3'h4
`define WHEEL_CHARS 5'h1E
`define CODE_DP 5'h0A
`define CODE_BLANK 5'h1F
`define GRP_LAST 2'h2

// ----------------------------------------------------------------
// controller states
// ----------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_ENGAGE 3'h1
`define ST_START 3'h2
`define ST_COLUMN 3'h3
`define ST_FEED 3'h4

// ----------------------------------------------------------------
// column kinds
// ----------------------------------------------------------------
`define PH_SYM0 3'h0
`define PH_SYM1 3'h1
`define PH_DIG 3'h2
`define PH_DP 3'h3
`define PH_SEP 3'h4

`endif

//--- verilog/sync_edge.v
// Purpose: two-flop synchroniser with rising edge detect
// Assumes: input is asynchronous to clk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module sync_edge (
  input wire clk,
  input wire srst,
  input wire pin,
  output wire level,
  output wire rise
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  // synchronise then remember previous level
  always @(posedge clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
endmodule
